// >>> core/flash_erase_power_id_cmds.sv
// Purpose: Command handling for block and chip erase, quad mode, deep sleep and ID reads
// Assumes: sclk runs only while cs_n is low; mode flags change only while cs_n is high
// Notes: Link side shifts bits; mclk side decodes once select rises
`timescale 1ns/1ns
module flash_erase_power_id_cmds #(
   parameter int FLASH_ADDR_W = 27,
   parameter int ERASE_32K_TIME_US = 1000,
   parameter int ERASE_64K_TIME_US = 2000,
   parameter int WHOLE_ERASE_TIME_US = 20000,
   parameter int ERASE_32K_CYC = ERASE_32K_TIME_US * 1000 / flash_cmd_pkg::CLK_PERIOD_NS,
   parameter int ERASE_64K_CYC = ERASE_64K_TIME_US * 1000 / flash_cmd_pkg::CLK_PERIOD_NS,
   parameter int WHOLE_ERASE_CYC = WHOLE_ERASE_TIME_US * 1000 / flash_cmd_pkg::CLK_PERIOD_NS,
   // Identity values below are arbitrary
   parameter logic [7:0] MAKER_CODE = 8'h5A,
   parameter logic [7:0] MEM_TYPE = 8'h3C,
   parameter logic [7:0] CAPACITY = 8'h1B,
   parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEFFEDCBA9876543210
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   input wire logic addr4_mode,
   input wire logic [4:0] protect_level_bits,
   input wire logic write_permit_latch,
   input wire logic other_cycle_busy,
   output logic busy_progress_flag,
   output logic write_permit_clear,
   output logic erase_start,
   output logic erase_done,
   output logic [1:0] erase_kind,
   output logic [31:0] erase_addr,
   output logic deep_sleep,
   output logic four_line_cmd_mode
);
   import flash_cmd_pkg::*;

   // ************************************************
   // Link side, clocked by the host serial clock
   // ************************************************
   logic frame_live_reg;
   logic [7:0] bits_reg;
   logic [7:0] bits_next;
   logic [7:0] bits_base;
   logic [39:0] shift_reg;
   logic [39:0] shift_next;
   logic [7:0] op_reg;
   logic frame_tog_reg;
   logic blk_s1_reg;
   logic blk_s2_reg;
   logic [7:0] addr_bits;
   logic [7:0] uid_start;
   logic [7:0] out_shift;
   logic [127:0] out_word;
   logic [127:0] out_bits;
   logic id_op;
   logic uid_op;
   logic block_cmds;

   // Four-byte mode widens every address phase
   assign addr_bits = addr4_mode ? ADDR4_BITS : ADDR3_BITS; // see [RULE_22]
   assign uid_start = CMD_BITS + addr_bits + DUMMY_BITS;

   // Select high ends the frame without needing a clock edge
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         frame_live_reg <= 1'b0;
      end else begin
         frame_live_reg <= 1'b1;
      end
   end

   always_comb begin
      bits_base = frame_live_reg ? bits_reg : 8'h00;
      if (four_line_cmd_mode) begin
         shift_next = {shift_reg[35:0], io_in};
         bits_next = (bits_base > BITS_SAT) ? bits_base : bits_base + 8'h04;
      end else begin
         shift_next = {shift_reg[38:0], io_in[0]};
         bits_next = (bits_base > BITS_SAT) ? bits_base : bits_base + 8'h01;
      end
   end

   // Captured words stay frozen once sclk stops, so mclk reads them after select rises
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         bits_reg <= 8'h00;
         shift_reg <= 40'h0;
      end else begin
         bits_reg <= bits_next;
         shift_reg <= shift_next;
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         op_reg <= 8'h00;
      end else if (bits_next == CMD_BITS) begin
         op_reg <= shift_next[7:0];
      end
   end

   // Toggle marks each new frame for the mclk side
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_tog_reg <= 1'b0;
      end else if (!frame_live_reg) begin
         frame_tog_reg <= ~frame_tog_reg;
      end
   end

   // Two-stage sync of the mclk-side refusal level
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         blk_s1_reg <= 1'b0;
         blk_s2_reg <= 1'b0;
      end else begin
         blk_s1_reg <= block_cmds;
         blk_s2_reg <= blk_s1_reg;
      end
   end

   assign id_op = (op_reg == OP_ID_A) || (op_reg == OP_ID_B);
   assign uid_op = (op_reg == OP_UID);

   always_comb begin
      out_word = 128'h0;
      out_shift = 8'h00;
      if (id_op) begin
         out_word = {MAKER_CODE, MEM_TYPE, CAPACITY, 104'h0}; // see [RULE_19]
         out_shift = bits_reg - CMD_BITS;
      end else if (uid_op) begin
         out_word = UNIQUE_ID; // see [RULE_18]
         out_shift = bits_reg - uid_start;
      end
      out_bits = out_word << out_shift;
   end

   // Output changes on falling edges; select high drops it at once
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         io_out <= 4'h0; // see [RULE_21]
         io_oe <= 4'h0;
      end else if (blk_s2_reg) begin
         io_out <= 4'h0; // see [RULE_20]
         io_oe <= 4'h0;
      end else if ((id_op && bits_reg >= CMD_BITS) || (uid_op && bits_reg >= uid_start)) begin
         if (four_line_cmd_mode) begin
            io_out <= out_bits[127:124];
            io_oe <= 4'hF;
         end else begin
            io_out <= {2'b00, out_bits[127], 1'b0};
            io_oe <= 4'h2;
         end
      end else begin
         io_out <= 4'h0;
         io_oe <= 4'h0;
      end
   end

   // ************************************************
   // Crossing into mclk
   // ************************************************
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_s3_reg;
   logic cs_q_reg;
   logic tog_s1_reg;
   logic tog_s2_reg;
   logic tog_seen_reg;
   logic cs_rise;
   logic new_frame;
   logic cmd_end;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
         cs_q_reg <= 1'b1;
      end else begin
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
         if (cs_s2_reg == cs_s3_reg) begin
            cs_q_reg <= cs_s3_reg;
         end
      end
   end

   assign cs_rise = (cs_s2_reg == cs_s3_reg) && cs_s3_reg && !cs_q_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_seen_reg <= 1'b0;
      end else begin
         tog_s1_reg <= frame_tog_reg;
         tog_s2_reg <= tog_s1_reg;
         if (cs_rise) begin
            tog_seen_reg <= tog_s2_reg;
         end
      end
   end

   // A frame with no clock edges carries no command
   assign new_frame = (tog_s2_reg != tog_seen_reg);
   assign cmd_end = cs_rise && new_frame;

   // ************************************************
   // Command decode
   // ************************************************
   power_state_t pwr_reg;
   logic busy_any;
   logic exact_cmd;
   logic exact_addr;
   logic [31:0] addr_full;
   logic rst_armed_reg;
   logic go_erase;
   logic [1:0] go_kind;
   logic go_sleep;
   logic go_release;
   logic go_reset;
   logic arm_set;

   assign busy_any = busy_progress_flag || other_cycle_busy;
   assign exact_cmd = (bits_reg == CMD_BITS);
   assign exact_addr = (bits_reg == CMD_BITS + addr_bits); // see [RULE_03]
   assign addr_full = addr4_mode ? shift_reg[31:0] : {8'h00, shift_reg[23:0]};
   assign block_cmds = busy_any || (pwr_reg != PWR_STANDBY);

   // Protected range grows downward from the top: 64KB at level one, doubling with each further level
   function automatic logic in_protect(input logic [31:0] a, input logic [4:0] lvl);
      logic [32:0] size;
      logic [32:0] span;
      size = 33'h1 << FLASH_ADDR_W;
      span = 33'h0;
      if (lvl != 5'h00) begin
         span = (33'h1 << BLK64_SHIFT) << (lvl - 5'h01);
      end
      if (lvl == 5'h00) begin
         in_protect = 1'b0;
      end else if (span >= size) begin
         in_protect = 1'b1;
      end else begin
         in_protect = ({1'b0, a} >= size - span);
      end
   endfunction

   always_comb begin
      go_erase = 1'b0;
      go_kind = KIND_NONE;
      go_sleep = 1'b0;
      go_release = 1'b0;
      go_reset = 1'b0;
      arm_set = 1'b0;
      if (cmd_end) begin
         unique case (pwr_reg)
            PWR_STANDBY: begin
               if (op_reg == OP_ERASE32_A || op_reg == OP_ERASE32_B) begin
                  // Latch set by the host beforehand gates every erase
                  go_erase = exact_addr && write_permit_latch && !busy_any // see [RULE_04]
                     && !in_protect({addr_full[31:BLK32_SHIFT], 15'h0}, protect_level_bits); // see [RULE_07]
                  go_kind = KIND_32K;
               end else if (op_reg == OP_ERASE64_A || op_reg == OP_ERASE64_B) begin
                  go_erase = exact_addr && write_permit_latch && !busy_any
                     && !in_protect({addr_full[31:BLK64_SHIFT], 16'h0}, protect_level_bits); // see [RULE_07]
                  go_kind = KIND_64K;
               end else if (op_reg == OP_CHIP_A || op_reg == OP_CHIP_B) begin
                  go_erase = exact_cmd && write_permit_latch && !busy_any // see [RULE_08]
                     && (protect_level_bits == 5'h00); // see [RULE_09]
                  go_kind = KIND_CHIP;
               end else if (op_reg == OP_SLEEP) begin
                  go_sleep = exact_cmd && !busy_any; // see [RULE_14]
               end
            end
            PWR_SLEEP: begin
               if (op_reg == OP_RELEASE) begin
                  go_release = exact_cmd && !busy_any; // see [RULE_17]
               end else if (op_reg == OP_RST_EN) begin
                  arm_set = exact_cmd;
               end else if (op_reg == OP_RST) begin
                  go_reset = exact_cmd && rst_armed_reg; // see [RULE_13]
               end
            end
            PWR_ENTERING, PWR_WAKING: begin
               go_erase = 1'b0; // see [RULE_16]
            end
         endcase
      end
   end

   // ************************************************
   // Power state
   // ************************************************
   logic [15:0] pwr_cnt_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pwr_reg <= PWR_STANDBY; // see [RULE_15]
         pwr_cnt_reg <= 16'h0000;
      end else begin
         unique case (pwr_reg)
            PWR_STANDBY: begin
               if (go_sleep) begin
                  pwr_reg <= PWR_ENTERING;
                  pwr_cnt_reg <= 16'(SLEEP_ENTRY_CYC - 1);
               end
            end
            PWR_ENTERING: begin
               if (pwr_cnt_reg == 16'h0000) begin
                  pwr_reg <= PWR_SLEEP; // see [RULE_12]
               end else begin
                  pwr_cnt_reg <= pwr_cnt_reg - 16'h0001;
               end
            end
            PWR_SLEEP: begin
               if (go_reset) begin
                  pwr_reg <= PWR_STANDBY;
               end else if (go_release) begin
                  pwr_reg <= PWR_WAKING;
                  pwr_cnt_reg <= 16'(RELEASE_CYC - 1);
               end
            end
            PWR_WAKING: begin
               if (pwr_cnt_reg == 16'h0000) begin
                  pwr_reg <= PWR_STANDBY; // see [RULE_16]
               end else begin
                  pwr_cnt_reg <= pwr_cnt_reg - 16'h0001;
               end
            end
         endcase
      end
   end

   // Reset pair must be back to back inside deep sleep
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rst_armed_reg <= 1'b0;
      end else if (cmd_end) begin
         rst_armed_reg <= arm_set;
      end
   end

   assign deep_sleep = (pwr_reg == PWR_SLEEP);

   // ************************************************
   // Command line mode
   // ************************************************
   // Only the mode bit moves; latch and other settings live elsewhere untouched
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         four_line_cmd_mode <= 1'b0;
      end else if (cmd_end && exact_cmd && pwr_reg == PWR_STANDBY) begin
         if (op_reg == OP_QUAD_ON) begin
            four_line_cmd_mode <= 1'b1; // see [RULE_10]
         end else if (op_reg == OP_QUAD_OFF) begin
            four_line_cmd_mode <= 1'b0; // see [RULE_11]
         end
      end
   end

   // ************************************************
   // Self-timed erase
   // ************************************************
   logic [31:0] erase_cnt_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         busy_progress_flag <= 1'b0;
         erase_cnt_reg <= 32'h0;
         erase_done <= 1'b0;
      end else begin
         erase_done <= 1'b0;
         if (go_erase) begin
            busy_progress_flag <= 1'b1; // see [RULE_05]
            unique case (go_kind)
               KIND_32K: erase_cnt_reg <= 32'(ERASE_32K_CYC - 1);
               KIND_64K: erase_cnt_reg <= 32'(ERASE_64K_CYC - 1);
               default: erase_cnt_reg <= 32'(WHOLE_ERASE_CYC - 1);
            endcase
         end else if (busy_progress_flag) begin
            if (erase_cnt_reg == 32'h0) begin
               busy_progress_flag <= 1'b0; // see [RULE_05]
               erase_done <= 1'b1;
            end else begin
               erase_cnt_reg <= erase_cnt_reg - 32'h1;
            end
         end
      end
   end

   // Latch clear is issued at the start, well before the cycle ends
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         erase_start <= 1'b0;
         write_permit_clear <= 1'b0;
         erase_kind <= KIND_NONE;
         erase_addr <= 32'h0;
      end else begin
         erase_start <= go_erase;
         write_permit_clear <= go_erase; // see [RULE_06]
         if (go_erase) begin
            erase_kind <= go_kind;
            unique case (go_kind)
               KIND_32K: erase_addr <= {addr_full[31:BLK32_SHIFT], 15'h0}; // see [RULE_01]
               KIND_64K: erase_addr <= {addr_full[31:BLK64_SHIFT], 16'h0}; // see [RULE_02]
               default: erase_addr <= 32'h0;
            endcase
         end
      end
   end
endmodule

// >>> common/flash_cmd_pkg.sv
// Purpose: Shared constants for the flash erase, power and ID command block
// Assumes: mclk at 100 MHz; serial clock arrives from the host on its own pin
// Notes: Opcodes, phase lengths, timing counts and power states
// Notes on behaviour
// [RULE_01] 32KB erase wipes the whole 32KB block holding the given address.
// [RULE_02] 64KB erase wipes the whole 64KB block holding the given address.
// [RULE_03] Erase runs only if select rises right after the last address bit.
// [RULE_04] Host sets the write permit latch before any erase.
// [RULE_05] Select rise starts timed erase; busy flag high until it ends.
// [RULE_06] Every erase cycle clears the write permit latch before finishing.
// [RULE_07] Block erase refused when the block lies in the protected range.
// [RULE_08] Chip erase is the opcode alone; select must rise after bit eight.
// [RULE_09] Chip erase runs only when all protect level bits are zero.
// [RULE_10] Quad enable switches to four-line commands; latch and settings kept.
// [RULE_11] Quad disable returns to single-line commands; latch and settings kept.
// [RULE_12] Accepted sleep command enters deep sleep after the entry delay.
// [RULE_13] In deep sleep only release or reset-enable then reset are heard.
// [RULE_14] Sleep command during a running cycle is rejected, cycle untouched.
// [RULE_15] Idle select rise means standby; power-up always starts in standby.
// [RULE_16] After release, nothing is accepted until the release time elapses.
// [RULE_17] Release command is ignored while the busy flag is set.
// [RULE_18] Unique ID read: opcode, zero address, dummy byte, then 128 bits out.
// [RULE_19] ID read shifts maker, type, capacity bytes out on falling clock.
// [RULE_20] ID read during an erase or program is not decoded.
// [RULE_21] Select rise ends ID output at once and returns to standby.
// [RULE_22] Address phase is three bytes, or four in four-byte address mode.
package flash_cmd_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [7:0] OP_ERASE32_A = 8'h52;
   localparam logic [7:0] OP_ERASE32_B = 8'h5C;
   localparam logic [7:0] OP_ERASE64_A = 8'hD8;
   localparam logic [7:0] OP_ERASE64_B = 8'hDC;
   localparam logic [7:0] OP_CHIP_A = 8'h60;
   localparam logic [7:0] OP_CHIP_B = 8'hC7;
   localparam logic [7:0] OP_QUAD_ON = 8'h38;
   localparam logic [7:0] OP_QUAD_OFF = 8'hFF;
   localparam logic [7:0] OP_SLEEP = 8'hB9;
   localparam logic [7:0] OP_RELEASE = 8'hAB;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_UID = 8'h4B;
   localparam logic [7:0] OP_ID_A = 8'h9F;
   localparam logic [7:0] OP_ID_B = 8'h9E;
   localparam logic [7:0] CMD_BITS = 8'h08;
   localparam logic [7:0] ADDR3_BITS = 8'h18;
   localparam logic [7:0] ADDR4_BITS = 8'h20;
   localparam logic [7:0] DUMMY_BITS = 8'h08;
   localparam logic [7:0] BITS_SAT = 8'hF0;
   localparam int BLK32_SHIFT = 15;
   localparam int BLK64_SHIFT = 16;
   localparam logic [1:0] KIND_NONE = 2'h0;
   localparam logic [1:0] KIND_32K = 2'h1;
   localparam logic [1:0] KIND_64K = 2'h2;
   localparam logic [1:0] KIND_CHIP = 2'h3;
   localparam int SLEEP_ENTRY_DELAY_NS = 3000;
   localparam int RELEASE_TIME_NS = 3000;
   localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_CYC = (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ID_WORD_W = 128;
   typedef enum logic [1:0] {
      PWR_STANDBY = 2'b00,
      PWR_ENTERING = 2'b01,
      PWR_SLEEP = 2'b11,
      PWR_WAKING = 2'b10
   } power_state_t;
endpackage

// >>> testbench/flash_erase_power_id_cmds_sva.sv
// Purpose: Concurrent checks on the erase, sleep and ID command block
// Assumes: Sees only the block's ports, all sampled on mclk
// Notes: Bound into every instance of the block
`timescale 1ns/1ns
module flash_erase_power_id_cmds_sva #(
   parameter int ERASE_32K_CYC = 20,
   parameter int ERASE_64K_CYC = 30,
   parameter int WHOLE_ERASE_CYC = 50
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic [3:0] io_oe,
   input wire logic [4:0] protect_level_bits,
   input wire logic busy_progress_flag,
   input wire logic write_permit_clear,
   input wire logic erase_start,
   input wire logic erase_done,
   input wire logic [1:0] erase_kind,
   input wire logic [31:0] erase_addr,
   input wire logic deep_sleep
);
   import flash_cmd_pkg::*;
   int busy_len_reg;
   int want;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   assign want = erase_kind == KIND_32K ? ERASE_32K_CYC : erase_kind == KIND_64K ? ERASE_64K_CYC : WHOLE_ERASE_CYC;
   // ********
   // Busy length since the last start
   // ********
   always_ff @(posedge mclk) begin
      if (!rst_n) busy_len_reg <= 0;
      else if (erase_start) busy_len_reg <= 1;
      else if (busy_progress_flag) busy_len_reg <= busy_len_reg + 1;
   end
   property p_start_flags;
      erase_start |-> busy_progress_flag && write_permit_clear && !$past(busy_progress_flag);
   endproperty
   a_start_flags: assert property (p_start_flags)
      else $error("erase start without busy or latch clear");
   property p_clear_only;
      write_permit_clear |-> erase_start;
   endproperty
   a_clear_only: assert property (p_clear_only)
      else $error("latch clear outside an erase start");
   property p_done_len;
      erase_done |-> $fell(busy_progress_flag) && busy_len_reg == want;
   endproperty
   a_done_len: assert property (p_done_len)
      else $error("erase busy length wrong");
   property p_blk32;
      erase_start && erase_kind == KIND_32K |-> erase_addr[14:0] == 15'h0000;
   endproperty
   a_blk32: assert property (p_blk32)
      else $error("32K block start not aligned");
   property p_blk64;
      erase_start && erase_kind == KIND_64K |-> erase_addr[15:0] == 16'h0000;
   endproperty
   a_blk64: assert property (p_blk64)
      else $error("64K block start not aligned");
   property p_chip;
      erase_start && erase_kind == KIND_CHIP |-> protect_level_bits == 5'h00 && erase_addr == 32'h0;
   endproperty
   a_chip: assert property (p_chip)
      else $error("chip erase with protection set");
   property p_sleep_idle;
      $rose(deep_sleep) |-> !busy_progress_flag;
   endproperty
   a_sleep_idle: assert property (p_sleep_idle)
      else $error("deep sleep entered while busy");
   property p_sleep_quiet;
      deep_sleep |-> !erase_start && io_oe == 4'h0;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("activity in deep sleep");
   property p_busy_mute;
      busy_progress_flag |-> io_oe == 4'h0;
   endproperty
   a_busy_mute: assert property (p_busy_mute)
      else $error("data driven during erase");
   property p_cs_release;
      cs_n [*2] |-> io_oe == 4'h0;
   endproperty
   a_cs_release: assert property (p_cs_release)
      else $error("data driven with select high");
endmodule
bind flash_erase_power_id_cmds flash_erase_power_id_cmds_sva #(.ERASE_32K_CYC(ERASE_32K_CYC),
   .ERASE_64K_CYC(ERASE_64K_CYC), .WHOLE_ERASE_CYC(WHOLE_ERASE_CYC)) i_sva (.*);

// >>> testbench/host_flash_model.sv
// Purpose: Host controller model driving select, serial clock and data pins
// Assumes: 12 ns serial clock, stopped outside frames
// Notes: Unused or released data pins toggle so no stale level is read
`timescale 1ns/1ns
module host_flash_model (
   output logic sclk,
   output logic cs_n,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe,
   input wire logic quad
);
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      io_in = 4'h5;
   end
   // Sends ntx bits MSB first, then reads nrx bits; early end allowed
   task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, output logic [127:0] rx);
      int w;
      logic [63:0] s;
      w = quad ? 4 : 1;
      rx = '0;
      #80;
      cs_n = 1'h0;
      for (int i = 0; i < ntx + nrx; i += w) begin
         s = tx >> (ntx - i - w);
         io_in = (i >= ntx) ? ~io_in : quad ? s[3:0] : {~io_in[3:1], s[0]};
         #6 sclk = 1'h1;
         if (i >= ntx) rx = {rx[126:0], io_oe[1] ? io_out[1] : ~rx[0]};
         #6 sclk = 1'h0;
      end
      #6 cs_n = 1'h1;
   endtask
endmodule

// >>> testbench/test_flash_erase_power_id_cmds.sv
// Purpose: Self-checking bench for the erase, sleep and ID command block
// Assumes: Host model drives the link at 12 ns; erase counts shortened
// Notes: Expected erase values come from the model in the erase task
`timescale 1ns/1ns
module test_flash_erase_power_id_cmds;
   import flash_cmd_pkg::*;
   localparam int C32 = 40, C64 = 60, CCH = 120;
   // Arbitrary identity values
   localparam logic [23:0] ID = 24'hA54219;
   localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF;
   logic mclk = 1'h0;
   logic rst_n = 1'h0;
   logic addr4_mode = 1'h0;
   logic write_permit_latch = 1'h1;
   logic other_cycle_busy = 1'h0;
   logic host_quad = 1'h0;
   logic [4:0] protect_level_bits = 5'h00;
   wire sclk, cs_n, busy_progress_flag, write_permit_clear, erase_start, erase_done, deep_sleep, four_line_cmd_mode;
   wire [3:0] io_in, io_out, io_oe;
   wire [1:0] erase_kind;
   wire [31:0] erase_addr;
   int error_cnt = 0, samples_checked = 0;
   int asleep = 0, n;
   logic [31:0] seed = 32'h00010B82;
   logic [127:0] rx;
   logic [7:0] mid_q[$];
   logic [7:0] ops[4] = '{OP_ERASE32_A, OP_ERASE32_B, OP_ERASE64_A, OP_ERASE64_B};
   flash_erase_power_id_cmds #(.ERASE_32K_CYC(C32), .ERASE_64K_CYC(C64), .WHOLE_ERASE_CYC(CCH),
      .MAKER_CODE(ID[23:16]), .MEM_TYPE(ID[15:8]), .CAPACITY(ID[7:0]), .UNIQUE_ID(UID)) i_flash_erase_power_id_cmds (.*);
   host_flash_model i_host_flash_model (.*, .quad(host_quad));
   always #5 mclk = ~mclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task tick;
      @(posedge mclk);
      #1;
   endtask
   task check(input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task setin(input logic [4:0] p, input logic l, input logic a4, input logic ob);
      @(negedge mclk);
      protect_level_bits = p;
      write_permit_latch = l;
      addr4_mode = a4;
      other_cycle_busy = ob;
   endtask
   task send(input logic [7:0] op);
      i_host_flash_model.xfer(64'(op), 8, 0, rx);
   endtask
   // ********
   // Erase with reference model; trim drops trailing bits
   // ********
   task automatic erase(input logic [7:0] op, input logic [31:0] a, input int trim);
      int ab, sh, cyc;
      logic [1:0] kind;
      longint t0, psz, ea;
      bit ok;
      ab = (op == OP_CHIP_A || op == OP_CHIP_B) ? 0 : addr4_mode ? 32 : 24;
      sh = (op == OP_ERASE32_A || op == OP_ERASE32_B) ? BLK32_SHIFT : BLK64_SHIFT;
      kind = ab == 0 ? KIND_CHIP : sh == BLK32_SHIFT ? KIND_32K : KIND_64K;
      cyc = kind == KIND_CHIP ? CCH : kind == KIND_32K ? C32 : C64;
      ea = ab == 0 ? 0 : (a >> sh) << sh;
      psz = protect_level_bits == 0 ? 0 : longint'(65536) << (protect_level_bits - 1);
      ok = write_permit_latch && !other_cycle_busy && trim == 0 && asleep == 0 &&
         (ab == 0 ? psz == 0 : ea + (longint'(1) << sh) <= (longint'(1) << 27) - psz);
      i_host_flash_model.xfer(((64'(op) << ab) | 64'(a)) >> trim, 8 + ab - trim, 0, rx);
      n = 0;
      while (erase_start !== 1'h1 && n < 30) begin
         tick;
         n++;
      end
      check(erase_start, ok);
      if (ok) begin
         check({write_permit_clear, erase_kind, erase_addr}, {1'h1, kind, ea[31:0]});
         t0 = $time;
         foreach (mid_q[k]) i_host_flash_model.xfer(64'(mid_q[k]), 8, mid_q[k] == OP_ID_A ? 24 : 0, rx);
         n = 0;
         while (busy_progress_flag === 1'h1 && n < 2000) begin
            tick;
            n++;
         end
         check(($time - t0) / 10, cyc);
         check({erase_done, deep_sleep}, 2'h2);
      end
      mid_q.delete();
   endtask
   task automatic idread(input logic [7:0] op, input int nb);
      logic [127:0] e;
      e = '0;
      for (int k = 0; k < nb; k++) e = {e[126:0], ID[23 - k]};
      i_host_flash_model.xfer(64'(op), 8, nb, rx);
      check(rx, e);
   endtask
   initial begin
      #300000;
      error_cnt++;
      conclude;
   end
   initial begin
      repeat (4) @(negedge mclk);
      rst_n = 1'h1;
      repeat (4) tick;
      check({busy_progress_flag, deep_sleep, four_line_cmd_mode, erase_start}, 4'h0);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         erase(ops[k], seed & 32'h00FFFFFF, 0);
      end
      erase(OP_ERASE32_B, seed & 32'h00FFFFFF, 1);
      erase(OP_CHIP_B, 0, 1);
      erase(OP_CHIP_A, 0, 0);
      $display("test erase done");
      setin(5'h01, 1'h1, 1'h1, 1'h0);
      seed = lfsr(seed);
      erase(OP_ERASE64_B, seed & 32'h07FFFFFF, 0);
      erase(OP_ERASE32_A, 32'h07FF8123, 0);
      erase(OP_ERASE64_A, 32'h07FEFFFF, 0);
      erase(OP_CHIP_B, 0, 0);
      setin(5'h00, 1'h0, 1'h0, 1'h0);
      erase(OP_ERASE64_A, 32'h00123456, 0);
      setin(5'h00, 1'h1, 1'h0, 1'h1);
      erase(OP_CHIP_A, 0, 0);
      setin(5'h00, 1'h1, 1'h0, 1'h0);
      mid_q = '{OP_SLEEP, OP_RELEASE, OP_ID_A};
      erase(OP_CHIP_A, 0, 0);
      $display("test protect and busy done");
      idread(OP_ID_A, 24);
      idread(OP_ID_B, 24);
      idread(OP_ID_A, 12);
      i_host_flash_model.xfer(64'(OP_UID) << 32, 40, 128, rx);
      check(rx, UID);
      $display("test id done");
      send(OP_SLEEP);
      n = 0;
      while (deep_sleep !== 1'h1 && n < 400) begin
         tick;
         n++;
      end
      check(n >= SLEEP_ENTRY_CYC && n <= SLEEP_ENTRY_CYC + 10, 1);
      asleep = 1;
      erase(OP_ERASE64_A, 0, 0);
      send(OP_RELEASE);
      repeat (10) tick;
      check(deep_sleep, 0);
      send(OP_QUAD_ON);
      repeat (8) tick;
      check(four_line_cmd_mode, 0);
      repeat (RELEASE_CYC) tick;
      asleep = 0;
      idread(OP_ID_A, 24);
      send(OP_SLEEP);
      repeat (SLEEP_ENTRY_CYC + 10) tick;
      check(deep_sleep, 1);
      send(OP_RST_EN);
      send(OP_RST);
      repeat (10) tick;
      check(deep_sleep, 0);
      repeat (RELEASE_CYC) tick;
      $display("test sleep done");
      send(OP_QUAD_ON);
      repeat (8) tick;
      check(four_line_cmd_mode, 1);
      host_quad = 1'h1;
      erase(OP_ERASE32_A, 32'h00ABCDEF, 0);
      send(OP_QUAD_OFF);
      repeat (8) tick;
      check(four_line_cmd_mode, 0);
      host_quad = 1'h0;
      $display("test quad done");
      conclude;
   end
endmodule
